// *** pcm_map.svh ***
// Purpose: Register offsets, field positions and reset values of the port
//          configuration and miscellaneous control block.
// Assumes: One aligned 32-bit word per register on the bus.
// Notes:   Printed offsets are not all multiples of four, so they are
//          kept as indices and the byte address is four times the index.
`ifndef PCM_MAP_SVH
`define PCM_MAP_SVH

`define PCM_IDX_PC_VALUE    7'h00
`define PCM_IDX_PC_DIR      7'h01
`define PCM_IDX_PC_STYLE    7'h02
`define PCM_IDX_PB_VALUE    7'h04
`define PCM_IDX_PB_DIR      7'h05
`define PCM_IDX_PB_STYLE    7'h06
`define PCM_IDX_PA_VALUE    7'h08
`define PCM_IDX_PA_DIR      7'h09
`define PCM_IDX_PA_STYLE    7'h0a
`define PCM_IDX_MISC1       7'h20
`define PCM_IDX_MISC2       7'h40

`define PCM_RST_BYTE        8'h00
`define PCM_G1_HI           7
`define PCM_G1_LO           6
`define PCM_CLKOUT_BIT      5
`define PCM_G0_HI           4
`define PCM_G0_LO           3
`define PCM_DIV_HI          2
`define PCM_DIV_LO          1
`define PCM_SLOW_BIT        0
`define PCM_MOSI_OFF_BIT    3
`define PCM_MISO_OFF_BIT    2
`define PCM_SS_OVR_BIT      1
`define PCM_SS_LVL_BIT      0
`define PCM_MISC2_MASK      8'h0f
`define PCM_CLK_PIN         2
`define PCM_SS_PIN          7
`define PCM_PB_BASE         8

`define PCM_DIV_BY2         6'h01
`define PCM_DIV_BY4         6'h02
`define PCM_DIV_BY8         6'h04
`define PCM_DIV_BY16        6'h08
`define PCM_DIV_BY32        6'h10

`endif

// *** pcm_pkg.sv ***
// Purpose: Types shared by the port configuration block.
// Assumes: Nothing beyond the map header.
// Notes:   Sense codes follow the two-bit field encoding.
package pcm_pkg;
    typedef enum logic [1:0] {
        PCM_FALL_LOW = 2'h0,
        PCM_RISE     = 2'h1,
        PCM_FALL     = 2'h2,
        PCM_BOTH     = 2'h3
    } pcm_sense_t;

    typedef struct packed {
        logic [7:0] value;
        logic [7:0] dir;
        logic [7:0] style;
    } pcm_port_t;

    typedef struct packed {
        logic       mosi_off;
        logic       miso_off;
        logic       ss_level;
    } pcm_spi_t;
endpackage

// *** pcm_top.sv ***
// Purpose: Three 8-bit port configuration banks and miscellaneous control
//          (interrupt sensing, clock out, slow clock, SPI pin overrides).
// Assumes: AHB-Lite slave, single word transfers, zero wait states.
// Notes:   Pins without a style bit are set by the parameter masks.
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "pcm_map.svh"

// Contract
// - Direction bit 0 makes the pin input, 1 output; freely writable.
// - Input pin: style 0 floating, style 1 pull-up.
// - Output pin: style 0 open drain, style 1 push-pull.
// - Pins lacking a style bit are configured by direction alone.
// - Reset clears all port registers; pins become floating inputs.
// - Value read gives latch for outputs, sampled pin for inputs.
// - Each interrupt group senses one of four pin events.
// - Bits 7:6 set group one sense for port B, optionally C.
// - Bits 4:3 set group zero sense for port A, optionally C.
// - Sense fields accept writes only while global mask is 1.
// - Sense fields and source option jointly pick group sources.
// - Clock-out enable puts CPU clock on clock_out_pin.
// - Divider codes 00,10,01,11 give oscillator /4,/8,/16,/32.
// - Slow select 0 gives oscillator/2, 1 uses divider field.
// - SPI pin control bits 7:4 read as zero.
// - Bit 3 set disables SPI master data output.
// - Bit 2 set disables SPI slave data output.
// - Override 0 takes select from pin, 1 from internal bit.
// - Internal select-level bit stands in for pin when overridden.
// - With internal select, slave_select_pin stays a port pin.
module pcm_top
    import pcm_pkg::*;
#(
    parameter logic [7:0] PA_STYLE_MASK = 8'hff,
    parameter logic [7:0] PB_STYLE_MASK = 8'hff,
    parameter logic [7:0] PC_STYLE_MASK = 8'hff
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic [23:0] pin_in,
    output logic      [23:0] pin_out,
    output logic      [23:0] pin_oe,
    output logic      [23:0] pin_pullup,
    input  wire logic        global_irq_mask,
    input  wire logic        irq_source_option,
    input  wire logic        osc_clk_en,
    output logic             cpu_clock_tick,
    output logic             irq_group_zero,
    output logic             irq_group_one,
    output logic             spi_mosi_en,
    output logic             spi_miso_en,
    output logic             spi_slave_select
);
    // Pins ordered {port A, port B, port C}, each bit 7 down to 0.
    pcm_port_t  port_a;
    pcm_port_t  port_b;
    pcm_port_t  port_c;
    logic [7:0] misc1;
    pcm_spi_t   spi;
    logic [23:0] sync_a;
    logic [23:0] sync_b;
    logic [23:0] prev;
    logic        wr_pend;
    logic [6:0]  wr_idx;
    logic        ahb_take;
    logic [5:0]  div_cnt;
    logic [5:0]  div_target;

    function automatic logic idx_ok(input logic [6:0] idx);
        idx_ok = idx inside {`PCM_IDX_PC_VALUE, `PCM_IDX_PC_DIR,
            `PCM_IDX_PC_STYLE, `PCM_IDX_PB_VALUE, `PCM_IDX_PB_DIR,
            `PCM_IDX_PB_STYLE, `PCM_IDX_PA_VALUE, `PCM_IDX_PA_DIR,
            `PCM_IDX_PA_STYLE, `PCM_IDX_MISC1, `PCM_IDX_MISC2};
    endfunction

    // Edge/level event for one pin under a sense code.
    function automatic logic sense_hit(input logic [1:0] code,
                                       input logic now,
                                       input logic was);
        unique case (pcm_sense_t'(code))
            PCM_FALL_LOW: sense_hit = !now;
            PCM_RISE:     sense_hit = now && !was;
            PCM_FALL:     sense_hit = !now && was;
            PCM_BOTH:     sense_hit = now != was;
        endcase
    endfunction

    // The slave never waits and never errors; unmapped reads give zero.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign ahb_take  = hsel && hready && htrans[1];

    // Capture the write address; data arrives in the following phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_idx  <= 7'h00;
        end else begin
            wr_pend <= ahb_take && hwrite && idx_ok(haddr[8:2]);
            wr_idx  <= haddr[8:2];
        end
    end

    // Port registers, freely written except style bits cut by the style masks, cleared at reset.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_a <= '0;
            port_b <= '0;
            port_c <= '0;
        end else if (wr_pend) begin
            unique case (wr_idx)
                `PCM_IDX_PA_VALUE: port_a.value <= hwdata[7:0];
                `PCM_IDX_PA_DIR:   port_a.dir   <= hwdata[7:0];
                `PCM_IDX_PA_STYLE: port_a.style <= hwdata[7:0] & PA_STYLE_MASK;
                `PCM_IDX_PB_VALUE: port_b.value <= hwdata[7:0];
                `PCM_IDX_PB_DIR:   port_b.dir   <= hwdata[7:0];
                `PCM_IDX_PB_STYLE: port_b.style <= hwdata[7:0] & PB_STYLE_MASK;
                `PCM_IDX_PC_VALUE: port_c.value <= hwdata[7:0];
                `PCM_IDX_PC_DIR:   port_c.dir   <= hwdata[7:0];
                `PCM_IDX_PC_STYLE: port_c.style <= hwdata[7:0] & PC_STYLE_MASK;
                default: ;
            endcase
        end
    end

    // Sense fields are kept unless interrupts are globally masked.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            misc1 <= `PCM_RST_BYTE;
        end else if (wr_pend && wr_idx == `PCM_IDX_MISC1) begin
            misc1[`PCM_CLKOUT_BIT] <= hwdata[`PCM_CLKOUT_BIT];
            misc1[`PCM_DIV_HI:`PCM_SLOW_BIT] <=
                hwdata[`PCM_DIV_HI:`PCM_SLOW_BIT];
            if (global_irq_mask) begin
                misc1[`PCM_G1_HI:`PCM_G1_LO] <= hwdata[`PCM_G1_HI:`PCM_G1_LO];
                misc1[`PCM_G0_HI:`PCM_G0_LO] <= hwdata[`PCM_G0_HI:`PCM_G0_LO];
            end
        end
    end

    // SPI pin control; the reserved upper nibble is not stored.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            spi <= '0;
        end else if (wr_pend && wr_idx == `PCM_IDX_MISC2) begin
            spi.mosi_off <= hwdata[`PCM_MOSI_OFF_BIT];
            spi.miso_off <= hwdata[`PCM_MISO_OFF_BIT];
            spi.ss_level <= hwdata[`PCM_SS_LVL_BIT];
        end
    end

    logic ss_override;
    // Select-source override, written with the other SPI pin bits.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ss_override <= 1'b0;
        end else if (wr_pend && wr_idx == `PCM_IDX_MISC2) begin
            ss_override <= hwdata[`PCM_SS_OVR_BIT];
        end
    end

    // Two-stage pin synchroniser; sync_b and its one-cycle delayed copy prev feed logic.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_a <= '0;
            sync_b <= '0;
            prev   <= '0;
        end else begin
            sync_a <= pin_in;
            sync_b <= sync_a;
            prev   <= sync_b;
        end
    end

    logic [23:0] dir_all;
    logic [23:0] val_all;
    logic [23:0] sty_all;
    assign dir_all = {port_a.dir, port_b.dir, port_c.dir};
    assign val_all = {port_a.value, port_b.value, port_c.value};
    assign sty_all = {port_a.style, port_b.style, port_c.style};

    // Read view: latch for outputs, synchronised pin for inputs.
    logic [23:0] view;
    assign view = (dir_all & val_all) | (~dir_all & sync_b);

    // Read data registered at the edge ending the address phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ahb_take && !hwrite) begin
            unique case (haddr[8:2])
                `PCM_IDX_PA_VALUE: hrdata <= {24'h00_0000, view[23:16]};
                `PCM_IDX_PA_DIR:   hrdata <= {24'h00_0000, port_a.dir};
                `PCM_IDX_PA_STYLE: hrdata <= {24'h00_0000, port_a.style};
                `PCM_IDX_PB_VALUE: hrdata <= {24'h00_0000, view[15:8]};
                `PCM_IDX_PB_DIR:   hrdata <= {24'h00_0000, port_b.dir};
                `PCM_IDX_PB_STYLE: hrdata <= {24'h00_0000, port_b.style};
                `PCM_IDX_PC_VALUE: hrdata <= {24'h00_0000, view[7:0]};
                `PCM_IDX_PC_DIR:   hrdata <= {24'h00_0000, port_c.dir};
                `PCM_IDX_PC_STYLE: hrdata <= {24'h00_0000, port_c.style};
                `PCM_IDX_MISC1:    hrdata <= {24'h00_0000, misc1};
                `PCM_IDX_MISC2:    hrdata <= {28'h000_0000, spi.mosi_off,
                    spi.miso_off, ss_override, spi.ss_level};
                default:           hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Pad control per pin; style masks cover pins with no style bit.
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            pin_pullup[i] = !dir_all[i] && sty_all[i];
            pin_out[i]    = val_all[i];
            // Open drain drives low only; push-pull drives both levels.
            pin_oe[i]     = dir_all[i] && (sty_all[i] || !val_all[i]);
        end
        if (misc1[`PCM_CLKOUT_BIT]) begin
            pin_out[`PCM_CLK_PIN] = cpu_clock_tick;
            pin_oe[`PCM_CLK_PIN]  = 1'b1;
            pin_pullup[`PCM_CLK_PIN] = 1'b0;
        end
    end

    // Slave select: pin level, or internal bit leaving the pin free.
    assign spi_slave_select = ss_override
                            ? spi.ss_level
                            : sync_b[`PCM_PB_BASE + `PCM_SS_PIN];
    assign spi_mosi_en = !spi.mosi_off;
    assign spi_miso_en = !spi.miso_off;

    // CPU clock divider; counts oscillator enables to one tick.
    always_comb begin
        if (!misc1[`PCM_SLOW_BIT]) begin
            div_target = `PCM_DIV_BY2;
        end else begin
            unique case (misc1[`PCM_DIV_HI:`PCM_DIV_LO])
                2'h0: div_target = `PCM_DIV_BY4;
                2'h2: div_target = `PCM_DIV_BY8;
                2'h1: div_target = `PCM_DIV_BY16;
                2'h3: div_target = `PCM_DIV_BY32;
            endcase
        end
    end

    // A new divider setting applies at once, to the half period in progress.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt        <= 6'h00;
            cpu_clock_tick <= 1'b0;
        end else if (osc_clk_en) begin
            if (div_cnt + 6'h01 >= div_target) begin
                div_cnt        <= 6'h00;
                cpu_clock_tick <= !cpu_clock_tick;
            end else begin
                div_cnt <= div_cnt + 6'h01;
            end
        end
    end

    // Interrupt request per group; port C joins the group chosen by
    // the source option. Only input pins with style 1 raise requests.
    logic [23:0] irq_en;
    logic [23:0] hit0;
    logic [23:0] hit1;
    assign irq_en = ~dir_all & sty_all;
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            hit0[i] = irq_en[i] &&
                sense_hit(misc1[`PCM_G0_HI:`PCM_G0_LO], sync_b[i], prev[i]);
            hit1[i] = irq_en[i] &&
                sense_hit(misc1[`PCM_G1_HI:`PCM_G1_LO], sync_b[i], prev[i]);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_group_zero <= 1'b0;
            irq_group_one  <= 1'b0;
        end else begin
            irq_group_zero <= (|hit0[23:16]) ||
                              (!irq_source_option && (|hit0[7:0]));
            irq_group_one  <= (|hit1[15:8]) ||
                              (irq_source_option && (|hit1[7:0]));
        end
    end

    // Checks.
    property p_sense_locked;
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend && wr_idx == `PCM_IDX_MISC1 && !global_irq_mask)
            |=> $stable(misc1[`PCM_G1_HI:`PCM_G1_LO])
                && $stable(misc1[`PCM_G0_HI:`PCM_G0_LO]);
    endproperty
    a_sense_locked: assert property (p_sense_locked)
        else $error("Sense field changed while unmasked.");

    property p_reserved_zero;
        @(posedge hclk) disable iff (!hresetn)
        (ahb_take && !hwrite && haddr[8:2] == `PCM_IDX_MISC2)
            |=> hrdata[31:4] == 28'h000_0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("Reserved bits read nonzero.");

    property p_mosi;
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend && wr_idx == `PCM_IDX_MISC2)
            |=> spi_mosi_en == !$past(hwdata[`PCM_MOSI_OFF_BIT]);
    endproperty
    a_mosi: assert property (p_mosi)
        else $error("Master output not disabled.");

    property p_miso;
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend && wr_idx == `PCM_IDX_MISC2)
            |=> spi_miso_en == !$past(hwdata[`PCM_MISO_OFF_BIT]);
    endproperty
    a_miso: assert property (p_miso)
        else $error("Slave output not enabled.");

    property p_ss_src;
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend && wr_idx == `PCM_IDX_MISC2 && hwdata[`PCM_SS_OVR_BIT])
            |=> spi_slave_select == $past(hwdata[`PCM_SS_LVL_BIT]);
    endproperty
    a_ss_src: assert property (p_ss_src)
        else $error("Select level not internal.");

    property p_dir_write;
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend && wr_idx == `PCM_IDX_PA_DIR)
            |=> port_a.dir == $past(hwdata[7:0]);
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("Direction write lost.");

    property p_read_view;
        @(posedge hclk) disable iff (!hresetn)
        (ahb_take && !hwrite && haddr[8:2] == `PCM_IDX_PB_VALUE)
            |=> hrdata[7:0] == $past(view[15:8]);
    endproperty
    a_read_view: assert property (p_read_view)
        else $error("Value read mismatch.");

    property p_clkout;
        @(posedge hclk) disable iff (!hresetn)
        misc1[`PCM_CLKOUT_BIT] |-> pin_oe[`PCM_CLK_PIN] &&
            pin_out[`PCM_CLK_PIN] == cpu_clock_tick;
    endproperty
    a_clkout: assert property (p_clkout)
        else $error("Clock not on clock-out pin.");

    property p_input_float;
        @(posedge hclk) disable iff (!hresetn)
        !dir_all[0] |-> !pin_oe[0] && pin_pullup[0] == sty_all[0];
    endproperty
    a_input_float: assert property (p_input_float)
        else $error("Input pad mode wrong.");

    c_irq0: cover property (@(posedge hclk) irq_group_zero);
    c_irq1: cover property (@(posedge hclk) irq_group_one);
    c_slow: cover property (@(posedge hclk) misc1[`PCM_SLOW_BIT]);
    c_masked_wr: cover property (@(posedge hclk)
        wr_pend && wr_idx == `PCM_IDX_MISC1 && !global_irq_mask);
    c_clkout: cover property (@(posedge hclk) misc1[`PCM_CLKOUT_BIT]);
endmodule

// *** pcm_pin_model.sv ***
// Purpose: Outside world of the 24 port pins: drivers and loose lines.
// Assumes: The block's own output enable wins over an outside driver.
// Notes:   A released pin without pull-up flips every cycle, so a read
//          of it never matches by luck.
`timescale 1ns/100ps
module pcm_pin_model (
    input  wire logic        hclk,
    input  wire logic [23:0] pin_out,
    input  wire logic [23:0] pin_oe,
    input  wire logic [23:0] pin_pullup,
    input  wire logic [23:0] ext_en,
    input  wire logic [23:0] ext_val,
    output logic      [23:0] pin_level
);
    logic [23:0] last_level = 24'h00_0000;
    // The previous level lets a floating pin show its inverse.
    always_ff @(posedge hclk) begin
        last_level <= pin_level;
    end
    // Block driver first, then outside driver, then pull-up or float.
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                     | (~pin_oe & ~ext_en & (pin_pullup | ~last_level));
endmodule

// *** pcm_top_tb.sv ***
// Purpose: Self-checking bench for the port configuration block.
// Assumes: Zero-wait bus slave; byte address is four times the index.
// Notes:   Expected reads come from a register model kept by the bench.
`timescale 1ns/100ps
`include "pcm_map.svh"
module pcm_top_tb
    import pcm_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, global_irq_mask;
    logic        irq_source_option, osc_clk_en;
    logic        hreadyout, hresp, cpu_clock_tick;
    logic        irq_group_zero, irq_group_one, spi_mosi_en;
    logic        spi_miso_en, spi_slave_select, sf, sr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    logic [31:0] rng_state = 32'h0000_002b;
    logic [23:0] pin_out, pin_oe, pin_pullup, pin_level, ext_en, ext_val;
    logic [7:0]  div_code[5] = '{8'h20, 8'h21, 8'h25, 8'h23, 8'h27};
    int          half_tab[5] = '{1, 2, 4, 8, 16};
    int          idx_tab[11] = '{0, 1, 2, 4, 5, 6, 8, 9, 10, 32, 64};
    int          num_errors, total_checks, p, g, exp_reg[int];

    pcm_top u_pcm_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pin_in(pin_level),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .global_irq_mask(global_irq_mask),
        .irq_source_option(irq_source_option), .osc_clk_en(osc_clk_en),
        .cpu_clock_tick(cpu_clock_tick), .irq_group_zero(irq_group_zero),
        .irq_group_one(irq_group_one),
        .spi_mosi_en(spi_mosi_en), .spi_miso_en(spi_miso_en),
        .spi_slave_select(spi_slave_select)
    );
    pcm_pin_model u_pcm_pin_model (
        .hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val),
        .pin_level(pin_level)
    );

    // Prints the counts and the verdict; every timeout ends here too.
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    function automatic logic [31:0] next_rand();
        rng_state ^= rng_state << 13;
        rng_state ^= rng_state >> 17;
        rng_state ^= rng_state << 5;
        return rng_state;
    endfunction

    // One single transfer; read data is taken at the edge ending the data
    // phase, before the slave can move it.
    task automatic bus(input logic wr, input int idx, input logic [7:0] wd);
        int n;
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= 32'(idx * 4);
        for (int ph = 0; ph < 2; ph++) begin
            n = 0;
            do begin
                @(posedge hclk);
                n++;
            end while (hreadyout !== 1'b1 && n < 20);
            if (hreadyout !== 1'b1) begin
                num_errors++;
                tally_and_finish();
            end
            if (ph == 0) begin
                hsel   <= 1'b0;
                htrans <= 2'h0;
                hwdata <= {24'h00_0000, wd};
            end
        end
        rdat = hrdata;
        check("response", 32'h0000_0000, {31'h0000_0000, hresp});
    endtask

    // Write and update the model; sense bits keep their old value while global_irq_mask is 0.
    task automatic wr(input int idx, input logic [7:0] v);
        bus(1'b1, idx, v);
        if (idx == `PCM_IDX_MISC1 && !global_irq_mask)
            v = (v & 8'h27) | (exp_reg[idx] & 8'hd8);
        if (idx == `PCM_IDX_MISC2)
            v &= `PCM_MISC2_MASK;
        if (exp_reg.exists(idx))
            exp_reg[idx] = v;
    endtask

    // Value registers show the latch for outputs and the pin for inputs.
    task automatic rd(input int idx);
        logic [31:0] e;
        e = exp_reg.exists(idx) ? exp_reg[idx] : 0;
        if (idx < 12 && idx % 4 == 0)
            e = (e & exp_reg[idx + 1]) | (pin_level >> (idx * 2)
                & ~exp_reg[idx + 1] & 32'h0000_00ff);
        bus(1'b0, idx, 8'h00);
        check($sformatf("register %0d", idx), e, rdat);
    endtask

    task automatic check_pins(input int b);
        logic [7:0] dir, sty, val, oe;
        dir = exp_reg[b + 1];
        sty = exp_reg[b + 2];
        val = exp_reg[b];
        oe  = dir & (sty | ~val);
        check("pin enable", oe, pin_oe[b * 2 +: 8]);
        check("pin level", val & oe, pin_out[b * 2 +: 8] & oe);
        check("pin pull-up", ~dir & sty, pin_pullup[b * 2 +: 8]);
    endtask

    task automatic watch(input int grp, output logic seen);
        seen = 1'b0;
        repeat (8) begin
            @(posedge hclk);
            seen |= grp ? irq_group_one : irq_group_zero;
        end
    endtask

    // Counts oscillator enables between toggles of the divided clock; the
    // first interval may still carry the old setting, so it is skipped.
    task automatic measure(input int half);
        int cnt, seen;
        logic prev;
        cnt = 0;
        seen = 0;
        prev = cpu_clock_tick;
        for (int n = 0; n < 400 && seen < 3; n++) begin
            @(posedge hclk);
            if (cpu_clock_tick !== prev) begin
                if (seen > 0)
                    check("half period", half, cnt);
                seen++;
                cnt = 0;
                prev = cpu_clock_tick;
            end
            cnt += osc_clk_en;
            check("clock pin", {1'b1, cpu_clock_tick}, {pin_oe[2], pin_out[2]});
        end
        if (seen < 3) begin
            num_errors++;
            tally_and_finish();
        end
    endtask

    // Free-running clock of 8 ns.
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // Oscillator enables change at random.
    always @(posedge hclk) begin
        osc_clk_en <= 1'(next_rand());
    end

    // Main sequence.
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        osc_clk_en = 1'b0;
        {global_irq_mask, irq_source_option, hsize} = 5'h12;
        ext_en = 24'hff_ffff;
        ext_val = 24'h00_0000;
        foreach (idx_tab[i]) exp_reg[idx_tab[i]] = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        check("reset pins", 0, pin_oe | pin_pullup);
        foreach (idx_tab[i]) rd(idx_tab[i]);
        wr(3, 8'h5a);
        rd(3);
        rd(7);
        repeat (6) begin
            for (int b = 0; b < 12; b += 4)
                for (int k = 0; k < 3; k++) wr(b + k, 8'(next_rand()));
            ext_val <= 24'(next_rand());
            repeat (4) @(posedge hclk);
            for (int b = 0; b < 12; b += 4) begin
                for (int k = 0; k < 3; k++) rd(b + k);
                check_pins(b);
            end
        end
        global_irq_mask <= 1'b0;
        wr(`PCM_IDX_MISC1, 8'hff);
        rd(`PCM_IDX_MISC1);
        global_irq_mask <= 1'b1;
        wr(`PCM_IDX_MISC1, 8'hd8);
        rd(`PCM_IDX_MISC1);
        for (int i = 0; i < 5; i++) begin
            wr(`PCM_IDX_MISC1, div_code[i]);
            measure(half_tab[i]);
        end
        wr(5, 8'h00);
        for (int v = 0; v < 16; v++) begin
            wr(`PCM_IDX_MISC2, 8'hf0 | v);
            rd(`PCM_IDX_MISC2);
            ext_val <= 24'(next_rand());
            repeat (4) @(posedge hclk);
            check("mosi on", !v[3], spi_mosi_en);
            check("miso on", !v[2], spi_miso_en);
            sf = v[1] ? v[0] : pin_level[15];
            check("select", sf, spi_slave_select);
            rd(4);
        end
        for (int k = 0; k < 11; k++) wr(k, 8'h00);
        for (int s = 0; s < 4; s++)
            for (int c = 0; c < 4; c++) begin
                p = s == 0 ? 16 : s == 1 ? 8 : 0;
                g = s % 2;
                irq_source_option <= s == 3;
                wr(p / 2 + 2, 8'h01);
                wr(`PCM_IDX_MISC1, g ? c << 6 : c << 3);
                ext_en[p] <= 1'b0;
                repeat (8) @(posedge hclk);
                ext_en[p] <= 1'b1;
                ext_val[p] <= 1'b0;
                watch(g, sf);
                ext_en[p] <= 1'b0;
                watch(g, sr);
                check("fall event", c != PCM_RISE, sf);
                if (c != PCM_FALL_LOW)
                    check("rise event", c % 2, sr);
                wr(p / 2 + 2, 8'h00);
            end
        ext_en <= 24'hff_ffff;
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        // Let the pin synchroniser refill before the value reads.
        repeat (2) @(posedge hclk);
        check("reset pins", 0, pin_oe | pin_pullup);
        foreach (idx_tab[i]) exp_reg[idx_tab[i]] = 0;
        foreach (idx_tab[i]) rd(idx_tab[i]);
        tally_and_finish();
    end
endmodule
